/* core/clk_sel_defs.vh */
// constants for the cpu clock selection and oscillator stabilization block
// assumes: included by bare name from the core files that need it
`ifndef CLK_SEL_DEFS_VH
`define CLK_SEL_DEFS_VH

// ********************************************************
// register addresses
// ********************************************************
`define ADDR_INTERNAL_OSC_MODE 16'hFFA0
`define ADDR_CPU_CLOCK_MODE 16'hFFA1
`define ADDR_MAIN_OSC_CONTROL 16'hFFA2
`define ADDR_OSC_STAB_STATUS 16'hFFA3
`define ADDR_OSC_STAB_SELECT 16'hFFA4

// ********************************************************
// field positions
// ********************************************************
`define INTERNAL_OSC_HALT_BIT 0
`define CPU_CLOCK_SELECT_BIT 0
`define CPU_CLOCK_STATUS_BIT 1
`define HIGHSPEED_OSC_HALT_BIT 7

// ********************************************************
// reset values
// ********************************************************
`define RST_INTERNAL_OSC_MODE 8'h00
`define RST_CPU_CLOCK_MODE 8'h00
`define RST_MAIN_OSC_CONTROL 8'h00
`define RST_OSC_STAB_STATUS 8'h00
`define RST_OSC_STAB_SELECT 3'h5

// ********************************************************
// stabilization select codes and threshold exponents
// ********************************************************
`define STAB_SEL_2P11 3'h1
`define STAB_SEL_2P13 3'h2
`define STAB_SEL_2P14 3'h3
`define STAB_SEL_2P15 3'h4
`define STAB_SEL_2P16 3'h5
`define STAB_EXP_2P11 11
`define STAB_EXP_2P13 13
`define STAB_EXP_2P14 14
`define STAB_EXP_2P15 15
`define STAB_EXP_2P16 16

// ********************************************************
// timing counts
// ********************************************************
`define RESET_WAIT_TICKS 5'h11

`endif

/* core/stab_counter.v */
// high-speed oscillator stabilization counter with thermometer status
// assumes: hs_tick is a one-cycle pulse per high-speed clock period,
// synchronous to ref_clk; limit is a power of two up to 2^16
`include "clk_sel_defs.vh"

module stab_counter (
   // clock and reset
   input wire ref_clk,
   input wire srst,
   // control
   input wire clear,
   input wire hs_tick,
   input wire [16:0] limit,
   // status
   output wire [4:0] status,
   output wire done
);

   reg [16:0] count_reg;
   reg [16:0] count_next;
   wire [4:0] status_flags;
   reg done_reg;

   // ********************************************************
   // counter
   // ********************************************************

   // count periods only while the oscillator actually ticks
   always @* begin
      count_next = count_reg;
      if (clear) begin
         count_next = 17'h00000;
      end else if (hs_tick && (count_reg < limit)) begin
         count_next = count_reg + 17'h00001;
      end
   end

   always @(posedge ref_clk) begin
      if (srst) begin
         count_reg <= 17'h00000;
         done_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         done_reg <= ~clear && (count_next >= limit);
      end
   end

   // ********************************************************
   // status bits, bit 4 is 2^11 down to bit 0 at 2^16
   // ********************************************************
   genvar i;
   generate
      for (i = 0; i < 5; i = i + 1) begin : g_thr
         localparam [16:0] THR = (i == 4) ? (17'h1 << `STAB_EXP_2P11) :
                                 (i == 3) ? (17'h1 << `STAB_EXP_2P13) :
                                 (i == 2) ? (17'h1 << `STAB_EXP_2P14) :
                                 (i == 1) ? (17'h1 << `STAB_EXP_2P15) :
                                 (17'h1 << `STAB_EXP_2P16);
         reg flag_reg;
         // sticky until a clearing event, one flop per threshold
         always @(posedge ref_clk) begin
            if (srst || clear) begin
               flag_reg <= 1'b0;
            end else if (count_next >= THR) begin
               flag_reg <= 1'b1;
            end
         end
         assign status_flags[i] = flag_reg;
      end
   endgenerate

   assign status = status_flags;
   assign done = done_reg;

endmodule

/* core/clock_select_ctrl.v */
// cpu clock selection, oscillator stop and stabilization status block
// assumes: oscillator ticks are one-cycle pulses synchronous to ref_clk;
// the cpu bus gives byte writes, single-bit writes and byte reads
//
// Summary of operation
// - internal oscillator halt bit works only if option allows and cpu not on it.
// - select bit 0 picks internal clock, 1 picks high-speed clock.
// - read-only status bit shows clock actually feeding the cpu.
// - on internal clock, peripheral clocks divide the internal oscillator.
// - high-speed halt bit stops that oscillator only while cpu on internal.
// - on subclock only the processor control off bit stops high-speed osc.
// - stabilization status clears on reset, stop entry and high-speed halts.
// - status is read-only, five bits in 4..0, bits 7..5 read zero.
// - status bits set in order from 2^11 and stay set.
// - select field codes 1..5 pick 2^11..2^16 waits, reset value 05h.
// - selected wait applies only when stop ends on high-speed clock.
// - after stop release the counter stops at the selected threshold.
// - wait counts only oscillation periods, not start-up delay.
// - select register takes byte writes only; mode and halt registers take bit writes too.
// - reset clears mode and halt registers to 00h, select register to 05h.
// - cpu clock held for 17 internal ticks after reset; oscs stop in reset.
// - internal oscillator always starts after reset release.
`include "clk_sel_defs.vh"

module clock_select_ctrl (
   // clock and reset
   input wire ref_clk,
   input wire srst,
   // cpu register access
   input wire [15:0] addr,
   input wire rd_en,
   input wire wr_en,
   input wire bit_wr,
   input wire [2:0] bit_sel,
   input wire bit_val,
   input wire [7:0] wdata,
   output wire [7:0] rdata,
   // option and processor clock control inputs
   input wire option_int_osc_stoppable,
   input wire subclk_select,
   input wire main_osc_off_bit,
   // standby control
   input wire stop_req,
   input wire stop_release,
   // oscillator period ticks
   input wire int_osc_tick,
   input wire hs_osc_tick,
   // clock control outputs
   output wire int_osc_run,
   output wire hs_osc_run,
   output wire cpu_clk_en,
   output wire cpu_on_highspeed,
   output wire periph_clk_internal
);

   // ********************************************************
   // wake state machine codes
   // ********************************************************
   localparam [1:0] ST_RESET_WAIT = 2'b00;
   localparam [1:0] ST_RUN = 2'b01;
   localparam [1:0] ST_STOP = 2'b10;
   localparam [1:0] ST_STAB_WAIT = 2'b11;

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [4:0] reset_cnt_reg;
   reg internal_osc_halt_bit_reg;
   reg cpu_clock_select_bit_reg;
   reg cpu_clock_status_bit_reg;
   reg highspeed_osc_halt_bit_reg;
   reg [2:0] stab_select_reg;
   reg stop_limit_reg;
   reg main_osc_off_prev_reg;
   reg [7:0] rdata_reg;
   reg int_osc_run_reg;
   reg hs_osc_run_reg;
   reg cpu_clk_en_reg;
   reg periph_clk_internal_reg;

   wire [4:0] stab_status;
   wire stab_done;
   reg [16:0] stab_limit;
   reg [7:0] cur_value;
   reg [7:0] wr_value;
   wire any_wr;
   wire hit_int_mode;
   wire hit_cpu_mode;
   wire hit_main_osc;
   wire hit_stab_sel;
   wire int_halt_allowed;
   wire int_halt_eff;
   wire hs_halt_eff;
   wire hs_halt_set;
   wire mcc_rise;
   wire stab_clear;

   // ********************************************************
   // address decode
   // ********************************************************
   assign any_wr = wr_en || bit_wr;
   assign hit_int_mode = (addr == `ADDR_INTERNAL_OSC_MODE);
   assign hit_cpu_mode = (addr == `ADDR_CPU_CLOCK_MODE);
   assign hit_main_osc = (addr == `ADDR_MAIN_OSC_CONTROL);
   assign hit_stab_sel = (addr == `ADDR_OSC_STAB_SELECT);

   // current register image, used for reads and bit merges
   always @* begin
      cur_value = 8'h00;
      case (addr)
         `ADDR_INTERNAL_OSC_MODE: begin
            cur_value[`INTERNAL_OSC_HALT_BIT] = internal_osc_halt_bit_reg;
         end
         `ADDR_CPU_CLOCK_MODE: begin
            cur_value[`CPU_CLOCK_SELECT_BIT] = cpu_clock_select_bit_reg;
            cur_value[`CPU_CLOCK_STATUS_BIT] = cpu_clock_status_bit_reg;
         end
         `ADDR_MAIN_OSC_CONTROL: begin
            cur_value[`HIGHSPEED_OSC_HALT_BIT] = highspeed_osc_halt_bit_reg;
         end
         `ADDR_OSC_STAB_STATUS: begin
            cur_value = {3'h0, stab_status};
         end
         `ADDR_OSC_STAB_SELECT: begin
            cur_value = {5'h00, stab_select_reg};
         end
         default: begin
            cur_value = 8'h00;
         end
      endcase
   end

   // byte write takes wdata; a bit write replaces one bit of the image
   always @* begin
      wr_value = wdata;
      if (bit_wr) begin
         wr_value = cur_value;
         wr_value[bit_sel] = bit_val;
      end
   end

   // ********************************************************
   // effective oscillator controls
   // ********************************************************

   // internal osc halt needs the option and the cpu off the internal clock
   assign int_halt_allowed = option_int_osc_stoppable &&
      ((cpu_clock_status_bit_reg && cpu_clock_select_bit_reg) ||
       subclk_select);
   assign int_halt_eff = internal_osc_halt_bit_reg && int_halt_allowed;

   // high-speed halt from this block only on internal clock, never subclock
   assign hs_halt_eff = (highspeed_osc_halt_bit_reg &&
      ~cpu_clock_status_bit_reg && ~subclk_select) ||
      (main_osc_off_bit && subclk_select);

   // a write that newly sets the high-speed halt bit
   assign hs_halt_set = any_wr && hit_main_osc &&
      wr_value[`HIGHSPEED_OSC_HALT_BIT] && ~highspeed_osc_halt_bit_reg;
   assign mcc_rise = main_osc_off_bit && ~main_osc_off_prev_reg;

   // events that restart the stabilization count
   assign stab_clear = (stop_req && (state_reg == ST_RUN)) ||
      hs_halt_set || mcc_rise;

   // ********************************************************
   // stabilization limit
   // ********************************************************

   // free count to 2^16, or the selected wait after a stop release
   always @* begin
      stab_limit = 17'h1 << `STAB_EXP_2P16;
      if (stop_limit_reg) begin
         case (stab_select_reg)
            `STAB_SEL_2P11: stab_limit = 17'h1 << `STAB_EXP_2P11;
            `STAB_SEL_2P13: stab_limit = 17'h1 << `STAB_EXP_2P13;
            `STAB_SEL_2P14: stab_limit = 17'h1 << `STAB_EXP_2P14;
            `STAB_SEL_2P15: stab_limit = 17'h1 << `STAB_EXP_2P15;
            default: stab_limit = 17'h1 << `STAB_EXP_2P16;
         endcase
      end
   end

   stab_counter u_stab_counter (
      .ref_clk(ref_clk),
      .srst(srst),
      .clear(stab_clear),
      .hs_tick(hs_osc_tick && hs_osc_run_reg),
      .limit(stab_limit),
      .status(stab_status),
      .done(stab_done)
   );

   // ********************************************************
   // register writes
   // ********************************************************

   // mode, halt and select registers
   always @(posedge ref_clk) begin
      if (srst) begin
         internal_osc_halt_bit_reg <= 1'b0;
         cpu_clock_select_bit_reg <= 1'b0;
         highspeed_osc_halt_bit_reg <= 1'b0;
         stab_select_reg <= `RST_OSC_STAB_SELECT;
      end else begin
         if (any_wr && hit_int_mode && int_halt_allowed) begin
            internal_osc_halt_bit_reg <=
               wr_value[`INTERNAL_OSC_HALT_BIT];
         end
         if (any_wr && hit_cpu_mode) begin
            // status bit is not writable
            cpu_clock_select_bit_reg <=
               wr_value[`CPU_CLOCK_SELECT_BIT];
         end
         if (any_wr && hit_main_osc) begin
            highspeed_osc_halt_bit_reg <=
               wr_value[`HIGHSPEED_OSC_HALT_BIT];
         end
         if (wr_en && hit_stab_sel) begin
            stab_select_reg <= wdata[2:0];
         end
      end
   end

   // registered read data; unmapped addresses read zero
   always @(posedge ref_clk) begin
      if (srst) begin
         rdata_reg <= 8'h00;
      end else if (rd_en) begin
         rdata_reg <= cur_value;
      end
   end

   // ********************************************************
   // cpu clock switch
   // ********************************************************

   // status follows select only on a tick of the running target source
   always @(posedge ref_clk) begin
      if (srst) begin
         cpu_clock_status_bit_reg <= 1'b0;
      end else if (state_reg == ST_RUN) begin
         if (cpu_clock_select_bit_reg && ~cpu_clock_status_bit_reg &&
             hs_osc_run_reg && hs_osc_tick) begin
            cpu_clock_status_bit_reg <= 1'b1;
         end else if (~cpu_clock_select_bit_reg &&
                      cpu_clock_status_bit_reg &&
                      int_osc_run_reg && int_osc_tick) begin
            cpu_clock_status_bit_reg <= 1'b0;
         end
      end
   end

   // ********************************************************
   // reset wait, stop and stabilization wait
   // ********************************************************
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_RESET_WAIT: begin
            if (int_osc_tick && (reset_cnt_reg == `RESET_WAIT_TICKS - 5'h1))
            begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (stop_req) begin
               state_next = ST_STOP;
            end
         end
         ST_STOP: begin
            if (stop_release) begin
               if (cpu_clock_status_bit_reg) begin
                  state_next = ST_STAB_WAIT;
               end else begin
                  state_next = ST_RUN;
               end
            end
         end
         ST_STAB_WAIT: begin
            if (stab_done) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_RESET_WAIT;
         end
      endcase
   end

   // state, reset wait count and stop limit flag
   always @(posedge ref_clk) begin
      if (srst) begin
         state_reg <= ST_RESET_WAIT;
         reset_cnt_reg <= 5'h00;
         stop_limit_reg <= 1'b0;
         main_osc_off_prev_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         main_osc_off_prev_reg <= main_osc_off_bit;
         if ((state_reg == ST_RESET_WAIT) && int_osc_tick) begin
            reset_cnt_reg <= reset_cnt_reg + 5'h01;
         end
         if ((state_reg == ST_STOP) && stop_release) begin
            stop_limit_reg <= 1'b1;
         end else if (stab_clear) begin
            stop_limit_reg <= 1'b0;
         end
      end
   end

   // ********************************************************
   // output flip-flops
   // ********************************************************

   // both oscillators stay off during reset
   always @(posedge ref_clk) begin
      if (srst) begin
         int_osc_run_reg <= 1'b0;
         hs_osc_run_reg <= 1'b0;
         cpu_clk_en_reg <= 1'b0;
         periph_clk_internal_reg <= 1'b1;
      end else begin
         int_osc_run_reg <= ~int_halt_eff;
         hs_osc_run_reg <= ~hs_halt_eff && (state_next != ST_STOP);
         cpu_clk_en_reg <= (state_next == ST_RUN);
         periph_clk_internal_reg <= ~cpu_clock_status_bit_reg;
      end
   end

   assign rdata = rdata_reg;
   assign int_osc_run = int_osc_run_reg;
   assign hs_osc_run = hs_osc_run_reg;
   assign cpu_clk_en = cpu_clk_en_reg;
   assign cpu_on_highspeed = cpu_clock_status_bit_reg;
   assign periph_clk_internal = periph_clk_internal_reg;

endmodule

/* verification/clock_select_ctrl_props.sv */
// assertions on the ports of the cpu clock select block
// assumes: bound onto clock_select_ctrl, one ref_clk domain
module clock_select_props (
   // clock and reset
   input logic ref_clk,
   input logic srst,
   // register read side
   input logic [15:0] addr,
   input logic rd_en,
   input logic [7:0] rdata,
   // control inputs
   input logic option_int_osc_stoppable,
   input logic subclk_select,
   input logic stop_req,
   input logic stop_release,
   input logic int_osc_tick,
   // clock control outputs
   input logic int_osc_run,
   input logic hs_osc_run,
   input logic cpu_clk_en,
   input logic cpu_on_highspeed,
   input logic periph_clk_internal
);
   logic [4:0] tick_cnt;
   logic [16:0] off_cnt;

   // ********
   // helpers
   // ********
   // internal ticks since reset, cycles with the cpu clock held off
   always @(posedge ref_clk) begin
      if (srst) begin
         tick_cnt <= 5'h00;
         off_cnt <= 17'h00000;
      end else begin
         if (int_osc_tick && tick_cnt != 5'h1F)
            tick_cnt <= tick_cnt + 5'h01;
         if (cpu_clk_en)
            off_cnt <= 17'h00000;
         else if (off_cnt != 17'h1FFFF)
            off_cnt <= off_cnt + 17'h00001;
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   // ********
   // checks
   // ********
   // stop entry drops cpu clock and high-speed osc together
   sequence s_halted;
      !cpu_clk_en && !hs_osc_run;
   endsequence
   // quick wake when no stabilization wait applies
   sequence s_resume;
      ##[1:2] cpu_clk_en;
   endsequence

   a_reset_hold: assert property (tick_cnt < 5'h11 |-> !cpu_clk_en)
      else $error("cpu clock before reset wait");
   a_osc_restart: assert property ($fell(srst) |->
      !int_osc_run ##1 (int_osc_run && hs_osc_run))
      else $error("oscillators wrong around reset release");
   a_stop_halts: assert property (stop_req && cpu_clk_en |=> s_halted)
      else $error("stop did not halt clocks");
   a_stop_wait: assert property (
      $rose(cpu_clk_en) && cpu_on_highspeed |-> off_cnt > 17'h007FF)
      else $error("cpu clock resumed before wait");
   a_wake_internal: assert property (
      stop_release && !cpu_clk_en && !cpu_on_highspeed |-> s_resume)
      else $error("wake on internal clock delayed");
   a_status_read: assert property (rd_en && addr == 16'hFFA1 |=>
      rdata[7:2] == 6'h00 && rdata[1] == $past(cpu_on_highspeed))
      else $error("clock status read mismatch");
   a_stab_upper: assert property (
      rd_en && addr == 16'hFFA3 |=> rdata[7:5] == 3'h0)
      else $error("stabilization upper bits set");
   a_status_source: assert property (
      $rose(cpu_on_highspeed) |-> hs_osc_run && $past(hs_osc_run))
      else $error("status moved without high-speed osc");
   a_hs_halt_gate: assert property ($fell(hs_osc_run) &&
      !$past(stop_req) && !$past(subclk_select) |-> !cpu_on_highspeed)
      else $error("high-speed osc halted while in use");
   a_int_halt_gate: assert property ($fell(int_osc_run) |->
      $past(option_int_osc_stoppable) &&
      ($past(cpu_on_highspeed) || $past(subclk_select)))
      else $error("internal osc halted when not allowed");
   a_periph_follow: assert property (
      $fell(cpu_on_highspeed) |-> ##[0:2] periph_clk_internal)
      else $error("peripherals not on internal clock");
endmodule

bind clock_select_ctrl clock_select_props i_props (
   .ref_clk(ref_clk), .srst(srst), .addr(addr), .rd_en(rd_en),
   .rdata(rdata), .option_int_osc_stoppable(option_int_osc_stoppable),
   .subclk_select(subclk_select), .stop_req(stop_req),
   .stop_release(stop_release), .int_osc_tick(int_osc_tick),
   .int_osc_run(int_osc_run), .hs_osc_run(hs_osc_run),
   .cpu_clk_en(cpu_clk_en), .cpu_on_highspeed(cpu_on_highspeed),
   .periph_clk_internal(periph_clk_internal));

/* verification/cpu_clock_select_osc_stabilization_tb_top.sv */
// self-checking bench for the cpu clock select block
// assumes: clock_select_ctrl and its checker are compiled first
module cpu_clock_select_osc_stabilization_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WR = 0, BW = 1, RD = 2;
   logic ref_clk, srst, rd_en, wr_en, bit_wr, bit_val;
   logic [15:0] addr;
   logic [2:0] bit_sel;
   logic [7:0] wdata, rdata;
   logic option_int_osc_stoppable, subclk_select, main_osc_off_bit;
   logic stop_req, stop_release, int_osc_tick, hs_osc_tick, rnd_tick;
   logic man_tick;
   logic int_osc_run, hs_osc_run, cpu_clk_en, cpu_on_highspeed;
   logic periph_clk_internal;
   int fails, checked, cyc, n, t;

   clock_select_ctrl i_clock_select_ctrl (
      .ref_clk(ref_clk), .srst(srst), .addr(addr), .rd_en(rd_en),
      .wr_en(wr_en), .bit_wr(bit_wr), .bit_sel(bit_sel),
      .bit_val(bit_val), .wdata(wdata), .rdata(rdata),
      .option_int_osc_stoppable(option_int_osc_stoppable),
      .subclk_select(subclk_select), .main_osc_off_bit(main_osc_off_bit),
      .stop_req(stop_req), .stop_release(stop_release),
      .int_osc_tick(int_osc_tick), .hs_osc_tick(hs_osc_tick),
      .int_osc_run(int_osc_run), .hs_osc_run(hs_osc_run),
      .cpu_clk_en(cpu_clk_en), .cpu_on_highspeed(cpu_on_highspeed),
      .periph_clk_internal(periph_clk_internal));

   // ********
   // clock, cycle count, random internal ticks
   // ********
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // cycles since reset release; internal ticks fixed, then random
   always @(posedge ref_clk) begin
      cyc <= srst ? 0 : cyc + 1;
      int_osc_tick <= rnd_tick ? (($urandom % 4) == 0) : man_tick;
   end

   // ********
   // helpers
   // ********
   // wait period of the high-speed clock for a select code
   function automatic int wt(input int c);
      return 1 << ((c == 1) ? 11 : c + 11);
   endfunction
   // thermometer status expected after c high-speed ticks
   function automatic logic [7:0] st(input int c);
      st = 8'h00;
      for (int i = 1; i < 6; i++)
         if (c >= wt(i))
            st[5 - i] = 1'b1;
   endfunction
   task automatic stop_test;
      $display("checked %0d failed %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   // one bus cycle; bit writes carry index in d[6:4], value in d[0]
   task automatic bus(input int k, input logic [15:0] a,
                      input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      bit_sel <= d[6:4];
      bit_val <= d[0];
      {wr_en, bit_wr, rd_en} <= {k == WR, k == BW, k == RD};
      @(posedge ref_clk);
      {wr_en, bit_wr, rd_en} <= 3'h0;
      #1;
      if (k == RD)
         chk8(rdata, d);
   endtask
   task automatic step(input int c);
      repeat (c) @(posedge ref_clk);
      #1;
   endtask
   // one stop request and release, each a single-cycle pulse
   task automatic stop_cycle(input int gap);
      @(posedge ref_clk);
      stop_req <= 1'b1;
      @(posedge ref_clk);
      stop_req <= 1'b0;
      step(gap - 1);
      chk1(cpu_clk_en | hs_osc_run, 1'b0);
      @(posedge ref_clk);
      stop_release <= 1'b1;
      @(posedge ref_clk);
      stop_release <= 1'b0;
   endtask

   // ********
   // watchdog
   // ********
   initial begin
      repeat (99000) @(posedge ref_clk);
      fails++;
      $display("[ERR] %0t watchdog expired", $time);
      stop_test();
   end

   // ********
   // main sequence
   // ********
   initial begin
      void'($urandom(32'h9E3E));
      srst = 1'b1;
      addr = 16'h0000;
      wdata = 8'h00;
      bit_sel = 3'h0;
      {rd_en, wr_en, bit_wr, bit_val, stop_req, stop_release} = 6'h00;
      {option_int_osc_stoppable, subclk_select, main_osc_off_bit} = 3'h0;
      {man_tick, rnd_tick, hs_osc_tick} = 3'h1;
      repeat (8) @(posedge ref_clk);
      srst <= 1'b0;
      man_tick <= 1'b1;
      #1;
      chk1(int_osc_run | hs_osc_run, 1'b0);
      step(17);
      chk1(cpu_clk_en, 1'b0);
      chk1(int_osc_run & hs_osc_run, 1'b1);
      @(posedge ref_clk);
      man_tick <= 1'b0;
      step(2);
      chk1(cpu_clk_en, 1'b1);
      @(posedge ref_clk);
      rnd_tick <= 1'b1;
      for (int i = 0; i < 6; i++)
         bus(RD, 16'hFFA0 + 16'(i), (i == 4) ? 8'h05 : 8'h00);
      bus(WR, 16'hFFA3, 8'($urandom));
      bus(RD, 16'hFFA3, 8'h00);
      bus(BW, 16'hFFA4, 8'h11);
      bus(RD, 16'hFFA4, 8'h05);
      bus(WR, 16'hFFA1, 8'h01);
      for (n = 0; cpu_on_highspeed !== 1'b1 && n < 64; n++)
         step(1);
      step(2);
      chk1(cpu_on_highspeed & ~periph_clk_internal, 1'b1);
      bus(RD, 16'hFFA1, 8'h03);
      bus(BW, 16'hFFA1, 8'h10);
      bus(RD, 16'hFFA1, 8'h03);
      bus(BW, 16'hFFA0, 8'h01);
      bus(RD, 16'hFFA0, 8'h00);
      @(posedge ref_clk);
      option_int_osc_stoppable <= 1'b1;
      bus(WR, 16'hFFA0, 8'h01);
      step(2);
      chk1(int_osc_run, 1'b0);
      bus(RD, 16'hFFA0, 8'h01);
      bus(BW, 16'hFFA0, 8'h00);
      step(2);
      chk1(int_osc_run, 1'b1);
      // status fills from the 2^11 bit upward and holds
      for (int i = 1; i < 6; i++) begin
         t = wt(i);
         step(t - 16 - cyc);
         bus(RD, 16'hFFA3, st(t - 1));
         step(t + 16 - cyc);
         bus(RD, 16'hFFA3, st(t));
      end
      // write each short wait code; stop on the high-speed clock with codes 1 to 3 only
      for (int c = 1; c < 5; c++) begin
         t = wt(c);
         bus(WR, 16'hFFA4, 8'(c));
         bus(RD, 16'hFFA4, 8'(c));
         if (c < 4) begin
            @(posedge ref_clk);
            hs_osc_tick <= 1'b0;
            stop_cycle(6);
            step(0);
            chk1(~cpu_clk_en & hs_osc_run, 1'b1);
            // oscillator start-up delay is not part of the wait
            repeat (10) @(posedge ref_clk);
            hs_osc_tick <= 1'b1;
            for (n = 10; cpu_clk_en !== 1'b1 && n < t + 40; n++)
               step(1);
            chk1(n >= t + 10 && n <= t + 16, 1'b1);
            bus(RD, 16'hFFA3, st(t));
         end
      end
      bus(WR, 16'hFFA2, 8'h80);
      step(2);
      chk1(hs_osc_run, 1'b1);
      bus(RD, 16'hFFA3, 8'h00);
      step(2100);
      bus(RD, 16'hFFA3, 8'h10);
      @(posedge ref_clk);
      main_osc_off_bit <= 1'b1;
      bus(RD, 16'hFFA3, 8'h00);
      @(posedge ref_clk);
      main_osc_off_bit <= 1'b0;
      bus(WR, 16'hFFA1, 8'h00);
      for (n = 0; cpu_on_highspeed !== 1'b0 && n < 200; n++)
         step(1);
      step(2);
      chk1(cpu_on_highspeed, 1'b0);
      chk1(periph_clk_internal & ~hs_osc_run, 1'b1);
      bus(WR, 16'hFFA2, 8'h00);
      step(2);
      chk1(hs_osc_run, 1'b1);
      // stop and wake while the internal clock feeds the cpu
      stop_cycle(2);
      step(2);
      chk1(cpu_clk_en, 1'b1);
      // subclock: only the processor control off bit halts high-speed
      bus(WR, 16'hFFA1, 8'h01);
      step(4);
      chk1(cpu_on_highspeed, 1'b1);
      @(posedge ref_clk);
      subclk_select <= 1'b1;
      main_osc_off_bit <= 1'b1;
      step(2);
      chk1(hs_osc_run, 1'b0);
      bus(RD, 16'hFFA3, 8'h00);
      @(posedge ref_clk);
      main_osc_off_bit <= 1'b0;
      subclk_select <= 1'b0;
      step(2);
      chk1(hs_osc_run & cpu_on_highspeed, 1'b1);
      stop_test();
   end
endmodule
